/* File: verilog/rpt_pkg.sv */
`default_nettype none
package rpt_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [15:0] RESET_DELAY_MS = 16'd200;
   localparam logic [16:0] TRIP_STEP_MS   = 17'd10;
   localparam logic [6:0]  PCT_FULL       = 7'd100;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_PICKUP    = 12'h004;
   localparam logic [11:0] OFS_DELAY     = 12'h008;
   localparam logic [11:0] OFS_STATUS    = 12'h00c;
   localparam logic [11:0] OFS_EVENTS    = 12'h010;
   localparam logic [11:0] OFS_MASK      = 12'h014;
   localparam logic [11:0] OFS_OP_TIMER  = 12'h018;

   // Field positions
   localparam int unsigned CTRL_OP_LSB   = 0;
   localparam int unsigned CTRL_MODE_LSB = 4;
   localparam int unsigned STAT_PCT_LSB  = 8;
   localparam int unsigned EV_PICKUP     = 0;
   localparam int unsigned EV_TRIP       = 1;

   // Op codes and reset values
   localparam logic [2:0]  OP_ENABLE     = 3'h1;
   localparam logic [2:0]  OP_DISABLE    = 3'h5;
   localparam logic [7:0]  PICKUP_RESET  = 8'h4b;
   localparam logic [12:0] DELAY_RESET   = 13'h000a;

   typedef enum logic [1:0] {
      MODE_FREEZE    = 2'b00,
      MODE_BLOCK_ALL = 2'b01,
      MODE_BLOCK_OUT = 2'b10,
      MODE_NONE      = 2'b11
   } rpt_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_RESET = 2'b10,
      ST_TRIP  = 2'b11
   } rpt_state_type;
endpackage
`default_nettype wire

/* File: verilog/rpt_tick_if.sv */
`default_nettype none
interface rpt_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface
`default_nettype wire

/* File: verilog/rpt_tick_gen.sv */
`default_nettype none
module rpt_tick_gen #(
   parameter int unsigned TICK_CYCLES = rpt_pkg::TICK_CYCLES
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   rpt_tick_if.src     tick_bus
);
   import rpt_pkg::*;

   localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          tick_r;
   wire           wrap = (cnt_r == CW'(TICK_CYCLES - 1));

   assign cnt_nxt       = wrap ? '0 : cnt_r + 1'b1;
   assign tick_bus.tick = tick_r;

   // One-cycle strobe every millisecond
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= wrap;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/rpt_trip_timer.sv */
`default_nettype none
module rpt_trip_timer #(
   parameter int unsigned TICK_CYCLES = rpt_pkg::TICK_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [15:0] NEG_SEQ_CURRENT,
   input  wire logic        BLOCK_IN,
   output logic             FAULT_DETECTED,
   output logic             OPERATE,
   output logic      [6:0]  ELAPSED_RATIO_PCT,
   output logic             IRQ
);
   import rpt_pkg::*;

   // ------------------------------------------------------------
   // Tick source
   // ------------------------------------------------------------
   rpt_tick_if tick_bus ();

   rpt_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk      (CLK),
      .rst_n    (RESETN),
      .tick_bus (tick_bus.src)
   );

   wire tick = tick_bus.tick;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [2:0]    op_code_r;
   rpt_mode_type  mode_r;
   logic [7:0]    pickup_r;
   logic [12:0]   delay_steps_r;
   logic [1:0]    events_r;
   logic [1:0]    events_nxt;
   logic [1:0]    mask_r;
   logic [31:0]   prdata_r;

   rpt_state_type state_r;
   rpt_state_type state_nxt;
   logic [15:0]   op_timer_r;
   logic [15:0]   op_timer_nxt;
   logic [15:0]   rst_timer_r;
   logic [15:0]   rst_timer_nxt;
   logic          fault_r;
   logic          operate_r;
   logic          operate_nxt;
   logic [6:0]    pct_r;
   logic [6:0]    pct_nxt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire wr_en     = PSEL & PENABLE & PWRITE;
   wire hit_ctrl  = (PADDR == OFS_CTRL);
   wire hit_pick  = (PADDR == OFS_PICKUP);
   wire hit_delay = (PADDR == OFS_DELAY);
   wire hit_stat  = (PADDR == OFS_STATUS);
   wire hit_ev    = (PADDR == OFS_EVENTS);
   wire hit_mask  = (PADDR == OFS_MASK);
   wire hit_timer = (PADDR == OFS_OP_TIMER);
   wire hit_any   = hit_ctrl | hit_pick | hit_delay | hit_stat | hit_ev | hit_mask | hit_timer;

   // Level detector and blocking qualifiers
   wire enabled    = (op_code_r == OP_ENABLE);
   wire level      = (NEG_SEQ_CURRENT > {8'h00, pickup_r});
   wire blk_all    = BLOCK_IN & (mode_r == MODE_BLOCK_ALL);
   wire blk_freeze = BLOCK_IN & (mode_r == MODE_FREEZE);
   wire blk_out    = BLOCK_IN & (mode_r == MODE_BLOCK_OUT);
   wire run_ok     = enabled & ~blk_all;

   // Trip delay in ms; a zero setting would divide by zero, so it counts as one step
   wire [12:0] steps_nz   = (delay_steps_r == 13'h0000) ? 13'h0001 : delay_steps_r;
   wire [16:0] delay_ms   = {4'h0, steps_nz} * TRIP_STEP_MS;
   wire        op_reached = ({1'b0, op_timer_r} + 17'd1 >= delay_ms);
   wire        rst_done   = (rst_timer_r + 16'd1 >= RESET_DELAY_MS);

   // Percentage is exact to the millisecond; the divider is combinational but
   // its result is only sampled into a flop, so the long path is tolerable at 25 MHz.
   wire [22:0] pct_num  = {7'h00, op_timer_r} * 23'd100;
   wire [22:0] pct_quo  = pct_num / {6'h00, delay_ms};
   wire [6:0]  pct_calc = (pct_quo > {16'h0000, PCT_FULL}) ? PCT_FULL : pct_quo[6:0];

   // ------------------------------------------------------------
   // Timer state machine
   // ------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      op_timer_nxt  = op_timer_r;
      rst_timer_nxt = rst_timer_r;
      if (!run_ok) begin
         state_nxt     = ST_IDLE;
         op_timer_nxt  = '0;
         rst_timer_nxt = '0;
      end else if (!blk_freeze) begin
         unique case (state_r)
            ST_IDLE: begin
               if (level) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!level) begin
                  state_nxt     = ST_RESET;
                  rst_timer_nxt = '0;
               end else if (tick) begin
                  op_timer_nxt = op_timer_r + 16'd1;
                  if (op_reached) begin
                     state_nxt = ST_TRIP;
                  end
               end
            end
            ST_RESET: begin
               if (level) begin
                  state_nxt = ST_RUN;
               end else if (tick) begin
                  rst_timer_nxt = rst_timer_r + 16'd1;
                  if (rst_done) begin
                     state_nxt     = ST_IDLE;
                     op_timer_nxt  = '0;
                     rst_timer_nxt = '0;
                  end
               end
            end
            ST_TRIP: begin
               // After operation the fault clears as soon as the current drops
               if (!level) begin
                  state_nxt    = ST_IDLE;
                  op_timer_nxt = '0;
               end
            end
         endcase
      end
   end

   // Operate is masked in block-output mode; freeze keeps an active operate
   assign operate_nxt = (state_nxt == ST_TRIP) & ~blk_out;
   assign pct_nxt     = (state_nxt == ST_TRIP) ? PCT_FULL :
                        (state_nxt == ST_IDLE) ? 7'h00 : pct_calc;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         state_r     <= ST_IDLE;
         op_timer_r  <= '0;
         rst_timer_r <= '0;
         fault_r     <= 1'b0;
         operate_r   <= 1'b0;
         pct_r       <= '0;
      end else begin
         state_r     <= state_nxt;
         op_timer_r  <= op_timer_nxt;
         rst_timer_r <= rst_timer_nxt;
         fault_r     <= (state_nxt != ST_IDLE);
         operate_r   <= operate_nxt;
         pct_r       <= pct_nxt;
      end
   end

   // ------------------------------------------------------------
   // Events and interrupt
   // ------------------------------------------------------------
   wire [1:0] ev_set = {operate_nxt & ~operate_r, (state_nxt != ST_IDLE) & ~fault_r};
   wire [1:0] ev_clr = (wr_en & hit_ev) ? PWDATA[1:0] : 2'b00;

   // Set wins over a simultaneous write-one clear
   assign events_nxt = (events_r & ~ev_clr) | ev_set;

   // ------------------------------------------------------------
   // APB register file
   // ------------------------------------------------------------
   wire [31:0] rd_mux =
      hit_ctrl  ? {26'h0, mode_r, 1'b0, op_code_r} :
      hit_pick  ? {24'h0, pickup_r} :
      hit_delay ? {19'h0, delay_steps_r} :
      hit_stat  ? {17'h0, pct_r, 4'h0, BLOCK_IN, level, operate_r, fault_r} :
      hit_ev    ? {30'h0, events_r} :
      hit_mask  ? {30'h0, mask_r} :
      hit_timer ? {16'h0, op_timer_r} : 32'h0000_0000;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         op_code_r     <= OP_ENABLE;
         mode_r        <= MODE_FREEZE;
         pickup_r      <= PICKUP_RESET;
         delay_steps_r <= DELAY_RESET;
         events_r      <= '0;
         mask_r        <= '0;
         prdata_r      <= '0;
      end else begin
         events_r <= events_nxt;
         if (PSEL & ~PENABLE) begin
            prdata_r <= rd_mux;
         end
         if (wr_en & hit_ctrl) begin
            op_code_r <= PWDATA[CTRL_OP_LSB +: 3];
            mode_r    <= rpt_mode_type'(PWDATA[CTRL_MODE_LSB +: 2]);
         end
         if (wr_en & hit_pick) begin
            pickup_r <= PWDATA[7:0];
         end
         if (wr_en & hit_delay) begin
            delay_steps_r <= PWDATA[12:0];
         end
         if (wr_en & hit_mask) begin
            mask_r <= PWDATA[1:0];
         end
      end
   end

   assign PRDATA            = prdata_r;
   assign PREADY            = 1'b1;
   assign PSLVERR           = PSEL & PENABLE & ~hit_any;
   assign FAULT_DETECTED    = fault_r;
   assign OPERATE           = operate_r;
   assign ELAPSED_RATIO_PCT = pct_r;
   assign IRQ               = |(events_r & mask_r);
endmodule
`default_nettype wire

/* File: tb/rpt_trip_asserts.sv */
`default_nettype none
module rpt_trip_asserts #(
   parameter int unsigned TICK_CYCLES = rpt_pkg::TICK_CYCLES
) (
   input wire logic       CLK,
   input wire logic       RESETN,
   input wire logic       PSEL,
   input wire logic       PENABLE,
   input wire logic       PREADY,
   input wire logic       PSLVERR,
   input wire logic       FAULT_DETECTED,
   input wire logic       OPERATE,
   input wire logic [6:0] ELAPSED_RATIO_PCT
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Port checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   AST_PREADY_HIGH: assert property (PREADY)
      else $error("pready low");
   AST_SLVERR_ACCESS: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("slverr outside access");
   AST_OPER_WITH_FAULT: assert property (OPERATE |-> FAULT_DETECTED)
      else $error("operate without fault");
   AST_OPER_AFTER_FAULT: assert property ($rose(OPERATE) |-> $past(FAULT_DETECTED))
      else $error("operate without prior pickup");
   AST_PCT_CEIL: assert property (ELAPSED_RATIO_PCT <= 7'd100)
      else $error("pct above full");
   AST_PCT_TRIP: assert property (OPERATE |-> ELAPSED_RATIO_PCT == 7'd100)
      else $error("pct not full at trip");
   AST_PCT_IDLE: assert property (!FAULT_DETECTED |-> ELAPSED_RATIO_PCT == 7'd0)
      else $error("pct not zero when idle");
   AST_CLEAR_ON_RESET: assert property ($rose(RESETN) |-> !FAULT_DETECTED && !OPERATE)
      else $error("outputs not cleared by reset");
endmodule
bind rpt_trip_timer rpt_trip_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
   .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .FAULT_DETECTED(FAULT_DETECTED), .OPERATE(OPERATE),
   .ELAPSED_RATIO_PCT(ELAPSED_RATIO_PCT));
`default_nettype wire

/* File: tb/rpt_meas_model.sv */
`default_nettype none
module rpt_meas_model (
   input  wire logic        clk,
   input  wire logic [15:0] level_req,
   output logic      [15:0] current = 16'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Magnitude arrives one clock late, as from a registered filter stage
   always @(posedge clk) begin
      current <= level_req;
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rpt_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and tasks
   // ------------------------------------------------------------
   logic        clk, resetn, psel, penable, pwrite, pready, slverr, se;
   logic        block_in, fault, oper, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, q2;
   logic [15:0] cur, neg;
   logic [6:0]  pct, p;
   int          err_total, checks_done, n;
   rpt_meas_model mdl_u (.clk(clk), .level_req(cur), .current(neg));
   rpt_trip_timer #(.TICK_CYCLES(10)) dut_u (
      .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr),
      .NEG_SEQ_CURRENT(neg), .BLOCK_IN(block_in), .FAULT_DETECTED(fault),
      .OPERATE(oper), .ELAPSED_RATIO_PCT(pct), .IRQ(irq));
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic set(input logic [15:0] c, input logic b);
      @(posedge clk);
      cur      <= c;
      block_in <= b;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      se = slverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q2);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd(OFS_CTRL, 32'h1, "ctrl");
      rd(OFS_PICKUP, 32'h4b, "pickup");
      rd(OFS_DELAY, 32'ha, "delay");
      rd(12'h01c, 32'h0, "unmapped");
      chk("slverr", {31'h0, se}, 32'h1);
      wr(OFS_STATUS, 32'hffffffff);
      rd(OFS_STATUS, 32'h0, "status ro");
   endtask
   task automatic t_trip;
      wr(OFS_DELAY, 32'h2);
      wr(OFS_MASK, 32'h3);
      set(16'h004b, 1'b0);
      tk(20);
      chk("fault at equal", {31'h0, fault}, 32'h0);
      set(16'h004c, 1'b0);
      tk(3);
      chk("fault", {31'h0, fault}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      p = pct;
      n = 0;
      while (pct === p && n < 20) begin
         tk(1);
         n++;
      end
      apb(1'b0, OFS_OP_TIMER, 32'h0, q);
      chk("timer step", q, 32'h1);
      chk("pct", {25'h0, pct}, q * 100 / 20);
      tk(150);
      chk("early trip", {31'h0, oper}, 32'h0);
      tk(55);
      chk("trip", {31'h0, oper}, 32'h1);
      chk("pct full", {25'h0, pct}, 32'd100);
      rd(OFS_EVENTS, 32'h3, "events");
      wr(OFS_EVENTS, 32'h3);
      rd(OFS_EVENTS, 32'h0, "events cleared");
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(OFS_MASK, 32'h0);
      set(16'h0000, 1'b0);
      tk(3);
      chk("drop fault", {31'h0, fault}, 32'h0);
      chk("drop pct", {25'h0, pct}, 32'h0);
   endtask
   task automatic t_hold;
      set(16'h0100, 1'b0);
      tk(53);
      chk("irq masked", {31'h0, irq}, 32'h0);
      set(16'h0000, 1'b0);
      tk(100);
      chk("held fault", {31'h0, fault}, 32'h1);
      apb(1'b0, OFS_OP_TIMER, 32'h0, q);
      tk(50);
      apb(1'b0, OFS_OP_TIMER, 32'h0, q2);
      chk("held timer", q2, q);
      chk("timer ran", {31'h0, q !== 32'h0}, 32'h1);
      tk(1640);
      chk("fault before reset", {31'h0, fault}, 32'h1);
      tk(230);
      chk("fault after reset", {31'h0, fault}, 32'h0);
      rd(OFS_OP_TIMER, 32'h0, "timer cleared");
   endtask
   task automatic t_modes;
      wr(OFS_CTRL, 32'h21);
      set(16'h0100, 1'b1);
      tk(240);
      chk("block out fault", {31'h0, fault}, 32'h1);
      chk("block out trip", {31'h0, oper}, 32'h0);
      wr(OFS_CTRL, 32'h5);
      tk(3);
      chk("disabled", {31'h0, fault}, 32'h0);
      wr(OFS_CTRL, 32'h11);
      tk(3);
      chk("block all", {31'h0, fault}, 32'h0);
      set(16'h0100, 1'b0);
      tk(3);
      chk("unblocked", {31'h0, fault}, 32'h1);
      set(16'h0100, 1'b1);
      tk(3);
      chk("block all pct", {25'h0, pct}, 32'h0);
      wr(OFS_CTRL, 32'h1);
      set(16'h0100, 1'b0);
      tk(240);
      chk("freeze trip", {31'h0, oper}, 32'h1);
      set(16'h0000, 1'b1);
      tk(20);
      chk("freeze hold", {31'h0, oper}, 32'h1);
      set(16'h0000, 1'b0);
      tk(3);
      chk("release", {31'h0, oper}, 32'h0);
   endtask
   task automatic t_rst;
      set(16'h0100, 1'b0);
      tk(215);
      chk("trip before reset", {31'h0, oper}, 32'h1);
      @(posedge clk);
      resetn <= 1'b0;
      cur    <= 16'h0000;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk("reset fault", {31'h0, fault}, 32'h0);
      chk("reset trip", {31'h0, oper}, 32'h0);
      chk("reset pct", {25'h0, pct}, 32'h0);
      rd(OFS_DELAY, 32'ha, "delay after reset");
      rd(OFS_OP_TIMER, 32'h0, "timer after reset");
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Whole run is about 3100 cycles; the limit leaves ample margin
   initial begin
      repeat (12000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cur = 16'h0;
      block_in = 1'b0;
      err_total = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_trip();
      t_hold();
      t_modes();
      t_rst();
      wrap_up();
   end
endmodule
`default_nettype wire
